// [sisss_pkg.sv]
// Package of constants and carrier types for the shared interrupt status and speed select block.
package sisss_pkg;
    localparam int          NUM_PORTS      = 4;
    localparam int          ADDR_W         = 10;
    localparam int          DATA_W         = 8;
    localparam int          SW_W           = 5;
    // Status block decode: address bits 4 through 8 come from the switches, bit 9 is fixed high.
    localparam int          BASE_LSB       = 4;
    localparam int          BASE_MSB       = 8;
    localparam int          FIXED_BIT      = 9;
    localparam logic        FIXED_LEVEL    = 1'h1;
    // Status bit levels: zero marks a pending request.
    localparam logic        LVL_PENDING    = 1'h0;
    localparam logic        LVL_IDLE       = 1'h1;
    localparam logic [3:0]  UNUSED_BITS    = 4'hf;
    localparam logic [7:0]  STATUS_RESET   = 8'hff;
    // Baud reference multipliers and the last count of the normal mode reference divider.
    localparam logic [3:0]  SPEED_NORMAL   = 4'h1;
    localparam logic [3:0]  SPEED_HIGH     = 4'h8;
    localparam logic [2:0]  HIGH_DIV_LAST  = 3'h7;

    // Host bus read strobe and address, travelling together.
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } sisss_bus_s;

    // Mode held in the speed selection.
    typedef enum logic [1:0] {
        SISSS_SPD_NORMAL = 2'b01,
        SISSS_SPD_HIGH   = 2'b10
    } sisss_spd_e;
endpackage : sisss_pkg

// [sisss_top.sv]
// Shared interrupt status register and baud speed selection for a four port serial module.
// Notes on behaviour
// R1: Status register identifies the interrupting port when all ports share one line.
// R2: A port UART interrupt request shows in the status register so one read finds it.
// R3: Bits 0 to 3 map to ports 1 to 4; 0 means pending, 1 idle.
// R4: Register answers any read within a 16-byte block aligned to the base.
// R5: Base from five switches on address bits 4 to 8, bit 9 high.
// R6: Speed switch picks normal 1x or high 8x baud reference.
// R7: Normal setting gives the conventional divisor rates, up to 115.2 Kbps.
// R8: High setting makes every divisor-programmed rate eight times its normal value.
// R9: Mode switch on selects shared interrupt, off selects independent lines.
// R10: Speed switch off selects normal, on selects high speed.
// R11: Unused bits 4 to 7 read 1; reads do not disturb the interrupt sources.
// R12: Host reads, services ports at 0, and re-reads until all port bits read 1.
`timescale 1ns/100ps
`default_nettype none
module sisss_top (
    input  wire logic                                clock,
    input  wire logic                                rstn,
    input  wire sisss_pkg::sisss_bus_s               bus,
    input  wire logic [sisss_pkg::SW_W-1:0]          status_base_switch_bank,
    input  wire logic                                irq_sharing_select,
    input  wire logic                                speed_switch,
    input  wire logic [sisss_pkg::NUM_PORTS-1:0]     uart_irq,
    input  wire logic                                baud_ref,
    output logic [sisss_pkg::DATA_W-1:0]             rd_data,
    output logic                                     rd_data_oe,
    output logic                                     shared_mode,
    output logic                                     shared_irq,
    output logic [sisss_pkg::NUM_PORTS-1:0]          port_irq,
    output logic                                     uart_clk_en,
    output logic [3:0]                               speed_factor
);
    // Status copy, decode hit, speed state and the normal mode reference divider.
    logic [sisss_pkg::DATA_W-1:0]    port_interrupt_pending_status;
    logic [sisss_pkg::NUM_PORTS-1:0] pend_n;
    logic                            hit;
    logic                            spd_high;
    sisss_pkg::sisss_spd_e           spd;
    logic [2:0]                      div_cnt;

    // Switch on reads as 0 so the switch level is compared directly with the address bits.
    assign hit = bus.rd
               && (bus.addr[sisss_pkg::FIXED_BIT] == sisss_pkg::FIXED_LEVEL)
               && (bus.addr[sisss_pkg::BASE_MSB:sisss_pkg::BASE_LSB]
                   == status_base_switch_bank); // [R4] [R5]

    // One inverter per port: a pending request reads as zero.
    genvar gi;
    generate
        for (gi = 0; gi < sisss_pkg::NUM_PORTS; gi++) begin : g_port
            assign pend_n[gi] = uart_irq[gi] ? sisss_pkg::LVL_PENDING
                                             : sisss_pkg::LVL_IDLE; // [R2] [R3]
        end
    endgenerate

    // Sample the port requests each cycle; no read ever writes back to the sources.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port_interrupt_pending_status <= sisss_pkg::STATUS_RESET;
        end else begin
            port_interrupt_pending_status <= {sisss_pkg::UNUSED_BITS, pend_n}; // [R1] [R11]
        end
    end

    // Read data is registered, so it is valid one cycle after the strobe.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data    <= sisss_pkg::STATUS_RESET;
            rd_data_oe <= 1'h0;
        end else begin
            rd_data_oe <= hit;
            if (hit) begin
                rd_data <= port_interrupt_pending_status; // [R4]
            end
        end
    end

    // Switch on means shared; independent lines pass each request through, registered one cycle later.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shared_mode <= 1'h1;
            shared_irq  <= 1'h0;
            port_irq    <= '0;
        end else begin
            shared_mode <= irq_sharing_select; // [R9]
            shared_irq  <= irq_sharing_select && (|uart_irq); // [R1] [R9]
            port_irq    <= irq_sharing_select ? '0 : uart_irq; // [R9]
        end
    end

    // Speed switch: off is normal, on is high.
    assign spd_high = speed_switch; // [R10]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            spd <= sisss_pkg::SISSS_SPD_NORMAL;
        end else begin
            spd <= spd_high ? sisss_pkg::SISSS_SPD_HIGH
                            : sisss_pkg::SISSS_SPD_NORMAL; // [R6] [R10]
        end
    end

    // The UART reference is the reference rate divided by eight in normal mode and undivided
    // in high mode, so the same divisor yields eight times the rate; this trades a fast
    // reference input for leaving the UART divisors untouched.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_cnt      <= '0;
            uart_clk_en  <= 1'h0;
            speed_factor <= sisss_pkg::SPEED_NORMAL;
        end else begin
            unique case (spd)
                sisss_pkg::SISSS_SPD_NORMAL: begin
                    speed_factor <= sisss_pkg::SPEED_NORMAL; // [R7]
                    if (baud_ref) begin
                        div_cnt <= div_cnt + 3'h1;
                    end
                    uart_clk_en <= baud_ref && (div_cnt == sisss_pkg::HIGH_DIV_LAST); // [R7]
                end
                sisss_pkg::SISSS_SPD_HIGH: begin
                    speed_factor <= sisss_pkg::SPEED_HIGH; // [R8]
                    div_cnt      <= '0;
                    uart_clk_en  <= baud_ref; // [R8]
                end
                default: begin
                    speed_factor <= sisss_pkg::SPEED_NORMAL;
                    div_cnt      <= '0;
                    uart_clk_en  <= 1'h0;
                end
            endcase
        end
    end

    // Checks on the status, decode, interrupt line and speed logic.
    AST_STATUS_MAP: assert property (@(posedge clock) disable iff (!rstn) // [R3]
        port_interrupt_pending_status[3:0] == ~$past(uart_irq))
        else $error("status bits do not mirror port requests inverted");
    AST_UNUSED_HIGH: assert property (@(posedge clock) disable iff (!rstn) // [R11]
        port_interrupt_pending_status[7:4] == sisss_pkg::UNUSED_BITS)
        else $error("unused status bits not high");
    AST_READ_ANSWER: assert property (@(posedge clock) disable iff (!rstn) // [R4]
        hit |=> rd_data_oe && rd_data == $past(port_interrupt_pending_status))
        else $error("read within block not answered next cycle");
    AST_NO_MISS: assert property (@(posedge clock) disable iff (!rstn) // [R5]
        (bus.rd && !bus.addr[sisss_pkg::FIXED_BIT]) |=> !rd_data_oe)
        else $error("read below 200H answered");
    AST_PEND_TO_READ: assert property (@(posedge clock) disable iff (!rstn) // [R2]
        (uart_irq[0] ##1 hit) |=> !rd_data[0])
        else $error("pending port 1 not seen by read");
    AST_SHARED_LINE: assert property (@(posedge clock) disable iff (!rstn) // [R9]
        (irq_sharing_select && |uart_irq) |=> shared_irq && port_irq == '0)
        else $error("shared line not raised in shared mode");
    AST_INDEP_LINES: assert property (@(posedge clock) disable iff (!rstn) // [R9]
        !irq_sharing_select |=> !shared_irq && port_irq == $past(uart_irq))
        else $error("independent lines wrong");
    AST_HIGH_SPEED: assert property (@(posedge clock) disable iff (!rstn) // [R8] [R10]
        speed_switch [*2] |=> speed_factor == sisss_pkg::SPEED_HIGH
                              && uart_clk_en == $past(baud_ref))
        else $error("high speed does not pass reference");
    AST_NORMAL_SPEED: assert property (@(posedge clock) disable iff (!rstn) // [R7] [R10]
        (!speed_switch [*2] ##0 !baud_ref) |=> !uart_clk_en
                              && speed_factor == sisss_pkg::SPEED_NORMAL)
        else $error("normal speed enable without reference");

    // The checks below pin down corners that the bench touches only lightly: a miss
    // must stay silent, held data must not drift, and the divider must count exactly
    // eight reference pulses. A wrong divider end point still gives the right speed
    // factor, so only the counter checks would catch it.

    // A cycle without a decoded read never enables the read data.
    AST_OE_NEEDS_HIT: assert property (@(posedge clock) disable iff (!rstn) // [R4]
        !hit |=> !rd_data_oe)
        else $error("read data enabled without a decoded read");

    // Read data keeps its last value between reads.
    AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rstn) // [R4]
        !hit |=> $stable(rd_data))
        else $error("read data changed without a read");

    // A read aimed at another 16-byte block is left unanswered.
    AST_OTHER_BLOCK: assert property (@(posedge clock) disable iff (!rstn) // [R5]
        (bus.rd && (bus.addr[sisss_pkg::BASE_MSB:sisss_pkg::BASE_LSB]
                    != status_base_switch_bank)) |=> !rd_data_oe)
        else $error("read outside the switch block answered");

    // Every answered read shows the unused bits high.
    AST_UPPER_READ: assert property (@(posedge clock) disable iff (!rstn) // [R11]
        rd_data_oe |-> rd_data[7:4] == sisss_pkg::UNUSED_BITS)
        else $error("unused bits low in read data");

    // With no port requesting, a read reports every port idle.
    AST_IDLE_READ: assert property (@(posedge clock) disable iff (!rstn) // [R3]
        ((uart_irq == '0) ##1 hit)
        |=> rd_data[3:0] == {sisss_pkg::NUM_PORTS{sisss_pkg::LVL_IDLE}})
        else $error("idle ports not read as ones");

    // The mode output follows the sharing switch one cycle later.
    AST_MODE_COPY: assert property (@(posedge clock) disable iff (!rstn) // [R9]
        1'b1 |=> shared_mode == $past(irq_sharing_select))
        else $error("mode output does not follow the sharing switch");

    // The shared line stays low while no port requests service.
    AST_SHARED_QUIET: assert property (@(posedge clock) disable iff (!rstn) // [R1] [R9]
        (uart_irq == '0) |=> !shared_irq)
        else $error("shared line raised with no request");

    // Shared mode keeps every per-port line quiet.
    AST_PORT_QUIET: assert property (@(posedge clock) disable iff (!rstn) // [R9]
        irq_sharing_select |=> port_irq == '0)
        else $error("per-port line driven in shared mode");

    // High speed keeps the divider parked, so a return to normal starts a full count.
    AST_HIGH_DIV_CLEAR: assert property (@(posedge clock) disable iff (!rstn) // [R8]
        (spd == sisss_pkg::SISSS_SPD_HIGH) |=> div_cnt == '0)
        else $error("divider not cleared in high speed");

    // The divider only advances on a reference pulse.
    AST_DIV_HOLD: assert property (@(posedge clock) disable iff (!rstn) // [R7]
        (spd == sisss_pkg::SISSS_SPD_NORMAL && !baud_ref) |=> $stable(div_cnt))
        else $error("divider moved without a reference pulse");

    // A normal speed enable comes exactly when the divider wraps.
    AST_NORMAL_EIGHTH: assert property (@(posedge clock) disable iff (!rstn) // [R7]
        (uart_clk_en && speed_factor == sisss_pkg::SPEED_NORMAL) |-> div_cnt == '0)
        else $error("normal speed enable not on the eighth pulse");

    // Main scenarios: reads with and without pending ports, enables in both speeds.
    COV_READ_PENDING: cover property (@(posedge clock) disable iff (!rstn)
        hit ##1 rd_data[3:0] != 4'hf);
    COV_READ_CLEAR: cover property (@(posedge clock) disable iff (!rstn)
        hit ##1 rd_data[3:0] == 4'hf);
    COV_HIGH_EN: cover property (@(posedge clock) disable iff (!rstn)
        spd == sisss_pkg::SISSS_SPD_HIGH && uart_clk_en);
    COV_NORMAL_EN: cover property (@(posedge clock) disable iff (!rstn)
        spd == sisss_pkg::SISSS_SPD_NORMAL && uart_clk_en);
endmodule : sisss_top
`default_nettype wire

// [sisss_host_model.sv]
// Behavioural host that reads the status register over the expansion bus.
`timescale 1ns/100ps
`default_nettype none
module sisss_host_model (
    input  wire logic                         clock,
    output var  sisss_pkg::sisss_bus_s        bus,
    input  wire logic [sisss_pkg::DATA_W-1:0] rd_data,
    input  wire logic                         rd_data_oe
);
    initial bus = '0;

    // One read: strobe held for one edge, then released with an inverted address.
    // The inversion keeps a stale address from looking like a held request.
    // The answer is taken mid-cycle, where it has settled, and the task then returns
    // on a rising edge so that the caller drives its next inputs on the edge.
    task automatic read(input  logic [sisss_pkg::ADDR_W-1:0] addr,
                        output logic [sisss_pkg::DATA_W-1:0] data,
                        output logic                         oe);
        @(posedge clock);
        bus <= '{rd: 1'b1, addr: addr};
        @(posedge clock);
        bus <= '{rd: 1'b0, addr: ~addr};
        @(negedge clock);
        oe   = rd_data_oe;
        data = rd_data;
        @(posedge clock);
    endtask
endmodule // sisss_host_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the status register and speed selection.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                  clock = 1'b0;
    logic                  rstn = 1'b0;
    sisss_pkg::sisss_bus_s bus;
    logic [4:0]            bank = 5'h10;
    logic                  sharing = 1'b1;
    logic                  speed = 1'b0;
    logic [3:0]            uart_irq = 4'h0;
    logic                  baud_ref = 1'b0;
    logic [7:0]            rd_data, d;
    logic                  rd_data_oe, oe, shared_mode, shared_irq, uart_clk_en;
    logic [3:0]            port_irq, speed_factor, pat;
    logic [9:0]            base;
    logic [4:0]            banks [4] = '{5'h00, 5'h1f, 5'h01, 5'h10};
    int                    n_errors = 0;
    int                    samples_checked = 0;
    int                    n_en = 0;

    sisss_top sisss_top_i (.clock(clock), .rstn(rstn), .bus(bus),
        .status_base_switch_bank(bank), .irq_sharing_select(sharing),
        .speed_switch(speed), .uart_irq(uart_irq), .baud_ref(baud_ref),
        .rd_data(rd_data), .rd_data_oe(rd_data_oe), .shared_mode(shared_mode),
        .shared_irq(shared_irq), .port_irq(port_irq), .uart_clk_en(uart_clk_en),
        .speed_factor(speed_factor));
    sisss_host_model sisss_host_model_i (.clock(clock), .bus(bus), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe));

    // Clock of 40 ns period.
    always #20 clock = ~clock;

    // Counts reference enables so the rate ratio can be judged.
    always @(posedge clock) if (uart_clk_en === 1'b1) n_en++;

    // Comparison shared by every scenario.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single exit point for both the normal end and the watchdog.
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Runs far longer than the tests need, so only a hang reaches it.
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge clock);
        check("reset data", rd_data, 8'hff);
        check("reset oe", {7'h0, rd_data_oe}, 8'h0);
        rstn <= 1'b1;
        // Decode at the top of the block, the adjacent block with address bit 4 flipped, and bit 9 low.
        foreach (banks[i]) begin
            bank <= banks[i];
            base = {1'b1, banks[i], 4'h0};
            @(posedge clock);
            sisss_host_model_i.read(base | 10'h00f, d, oe);
            check("oe top of block", {7'h0, oe}, 8'h1);
            check("idle status", d, 8'hff);
            sisss_host_model_i.read(base ^ 10'h010, d, oe);
            check("oe next block", {7'h0, oe}, 8'h0);
            sisss_host_model_i.read(base & 10'h1ff, d, oe);
            check("oe bit9 low", {7'h0, oe}, 8'h0);
        end
        // Each port alone and all together, in both interrupt modes.
        for (int m = 1; m >= 0; m--) begin
            sharing <= m[0];
            for (int i = 0; i < 5; i++) begin
                pat = (i < 4) ? 4'h1 << i : 4'hf;
                uart_irq <= pat;
                repeat (3) @(posedge clock);
                sisss_host_model_i.read(base + 10'(i), d, oe);
                check("status", d, {4'hf, ~pat});
                check("mode", {7'h0, shared_mode}, {7'h0, m[0]});
                check("shared line", {7'h0, shared_irq}, m ? 8'h1 : 8'h0);
                check("port lines", {4'h0, port_irq}, m ? 8'h0 : {4'h0, pat});
            end
        end
        // Host drains pending ports, re-reading until all port bits are idle.
        uart_irq <= 4'h5;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            sisss_host_model_i.read(base, d, oe);
            if (d[3:0] === 4'hf) break;
            uart_irq <= uart_irq & d[3:0];
            repeat (2) @(posedge clock);
        end
        check("drained", d, 8'hff);
        // Count enables over 64 reference pulses in each speed setting.
        for (int s = 0; s < 2; s++) begin
            speed <= s[0];
            repeat (4) @(posedge clock);
            n_en = 0;
            repeat (64) begin
                baud_ref <= 1'b1;
                @(posedge clock);
                baud_ref <= 1'b0;
                @(posedge clock);
            end
            repeat (3) @(posedge clock);
            check("speed factor", {4'h0, speed_factor}, s ? 8'h8 : 8'h1);
            check("enables", 8'(n_en), s ? 8'h40 : 8'h08);
        end
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
